/* hw/rsc_core.sv */
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - Framing mode: 0 transparent, 1 frames, 2 escaped; mode 2 adds no escapes and runs as mode 1.
// - Scan sends broadcast beacon request every channel.
// - Listen per channel 2^duration times 15.36 ms.
// - Scan covers 16 channels, or 12 high-power.
// - One record per beacon, five at most.
// - Record fields in fixed order, final CR.
// - Frame mode drops CRs; transparent ends fields.
// - Short address replaces serial when below 0xFFFF.
// - Address mode 0x02 short, 0x03 long.
// - Superframe spec bit layout fixed.
// - Signal strength as -dBm; timestamp three bytes.
// - Rate codes 0-7 select standard rates.
// - New rate waits for exit and OK.
// - Larger rate values up to 0x3D090 stored as the highest achievable rate not above them.
// - Rate read returns the stored value.
// - Code 7 runs at 111,111 baud.
// - Block transmission when channel energy exceeds threshold.
// - Threshold 0 to 0x50, resets 0x2C.
// - Exit command leaves command mode, applies rate.
module rsc_core #(
  parameter int SCAN_BASE_CYCLES = rsc_pkg::SCAN_BASE_CYC
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic                 high_power_pin,
  input  wire logic                 beacon_valid,
  input  wire rsc_pkg::rsc_beacon_t beacon_in,
  input  wire logic                 cca_req,
  input  wire logic [6:0]           cca_energy_mag,
  output logic                      cca_tx_go,
  output logic                      cca_tx_drop,
  output logic                      bcn_req_valid,
  output rsc_pkg::rsc_bcn_req_t     bcn_req,
  output logic                      resp_valid,
  output logic [7:0]                resp_data,
  input  wire logic                 resp_ready,
  output logic [1:0]                framing_mode,
  output logic [16:0]               uart_div,
  output logic                      cmd_mode
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic [16:0] std_div(input logic [2:0] code);
    case (code)
      3'h0:    std_div = 17'h00341;
      3'h1:    std_div = 17'h001a1;
      3'h2:    std_div = 17'h000d0;
      3'h3:    std_div = 17'h00068;
      3'h4:    std_div = 17'h00034;
      3'h5:    std_div = 17'h0001a;
      3'h6:    std_div = 17'h00011;
      default: std_div = 17'h00009;
    endcase
  endfunction : std_div

  function automatic logic [16:0] near_div(input logic [19:0] rate);
    logic [20:0] num;
    // Divisor rounds up, so the stored rate never exceeds the request.
    num = {1'b0, rsc_pkg::UART_TICK_HZ} + {1'b0, rate} - 21'h1;
    near_div = 17'(num / {1'b0, rate});
  endfunction : near_div

  function automatic logic use_short(input rsc_pkg::rsc_rec_t r);
    use_short = r.bcn.short_addr < rsc_pkg::BCAST_ADDR;
  endfunction : use_short

  function automatic logic [3:0] fld_len(input rsc_pkg::rsc_rec_t r,
                                         input logic [3:0] f);
    case (f)
      4'h0:       fld_len = use_short(r) ? 4'h2 : 4'h8;
      4'h1, 4'h7: fld_len = 4'h2;
      4'ha:       fld_len = 4'h3;
      default:    fld_len = 4'h1;
    endcase
  endfunction : fld_len

  function automatic logic [63:0] fld_val(input rsc_pkg::rsc_rec_t r,
                                          input logic [3:0] f);
    case (f)
      4'h0:    fld_val = use_short(r) ? {48'h0, r.bcn.short_addr}
                                      : r.bcn.long_addr;
      4'h1:    fld_val = {48'h0, r.bcn.net_id};
      4'h2:    fld_val = {56'h0, use_short(r) ? rsc_pkg::ADDR_MODE_SHORT
                                              : rsc_pkg::ADDR_MODE_LONG};
      4'h3:    fld_val = {56'h0, r.channel};
      4'h4:    fld_val = {63'h0, r.bcn.sec_use};
      4'h5:    fld_val = {63'h0, r.bcn.acl_entry};
      4'h6:    fld_val = {63'h0, r.bcn.sec_fail};
      4'h7:    fld_val = {48'h0, r.bcn.sf_spec};
      4'h8:    fld_val = {63'h0, r.bcn.gts_permit};
      4'h9:    fld_val = {56'h0, r.bcn.rssi_mag};
      default: fld_val = {40'h0, r.bcn.timestamp};
    endcase
  endfunction : fld_val

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_LISTEN, ST_FIELD, ST_SEP, ST_FINAL, ST_OK, ST_APPLY
  } rsc_state_t;

  rsc_state_t        state_ff;
  logic              hp_meta_ff;
  logic              hp_sync_ff;
  logic              wr_pend_ff;
  logic [7:0]        wr_addr_ff;
  logic [1:0]        framing_ff;
  logic [19:0]       rate_stored_ff;
  logic [16:0]       pend_div_ff;
  logic [16:0]       act_div_ff;
  logic [2:0]        scan_dur_ff;
  logic [6:0]        cca_thr_ff;
  logic              cmd_mode_ff;
  logic              scan_go_ff;
  logic              exit_go_ff;
  logic [4:0]        chan_left_ff;
  logic [7:0]        chan_ff;
  logic [27:0]       timer_ff;
  rsc_pkg::rsc_rec_t recs_ff [rsc_pkg::MAX_RECORDS];
  logic [2:0]        rec_cnt_ff;
  logic [2:0]        rec_idx_ff;
  logic [3:0]        fld_ff;
  logic [3:0]        byte_ff;
  logic [1:0]        ok_idx_ff;
  logic              bcn_req_valid_ff;
  logic              resp_valid_ff;
  logic [7:0]        resp_data_ff;
  logic              cca_go_ff;
  logic              cca_drop_ff;
  logic [31:0]       hrdata_ff;
  logic              addr_ok;
  logic              resp_free;
  logic              last_byte;
  logic              last_fld;
  logic [3:0]        cur_len;
  logic [63:0]       cur_val;
  logic [7:0]        cur_byte;
  logic [31:0]       nxt_rdata;
  logic [27:0]       listen_cyc;

  assign addr_ok    = hsel && htrans[1] && hready;
  assign resp_free  = !resp_valid_ff || resp_ready;
  assign cur_len    = fld_len(recs_ff[rec_idx_ff], fld_ff);
  assign cur_val    = fld_val(recs_ff[rec_idx_ff], fld_ff);
  assign cur_byte   = 8'(cur_val >> {byte_ff, 3'h0});
  assign last_byte  = byte_ff == 4'h0;
  assign last_fld   = fld_ff == 4'(rsc_pkg::FIELD_CNT - 1);
  assign listen_cyc = 28'(SCAN_BASE_CYCLES) << scan_dur_ff;

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hp_meta_ff <= 1'b0;
      hp_sync_ff <= 1'b0;
    end
    else
    begin
      hp_meta_ff <= high_power_pin;
      hp_sync_ff <= hp_meta_ff;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ==========================================================================
  always_comb
  begin
    nxt_rdata = 32'h0;
    if (haddr[7:0] == rsc_pkg::ADDR_FRAMING)
      nxt_rdata = {30'h0, framing_ff};
    else if (haddr[7:0] == rsc_pkg::ADDR_RATE)
      nxt_rdata = {12'h0, rate_stored_ff};
    else if (haddr[7:0] == rsc_pkg::ADDR_SCAN_DUR)
      nxt_rdata = {29'h0, scan_dur_ff};
    else if (haddr[7:0] == rsc_pkg::ADDR_CCA_THR)
      nxt_rdata = {25'h0, cca_thr_ff};
    else if (haddr[7:0] == rsc_pkg::ADDR_STATUS)
      nxt_rdata = {11'h0, hp_sync_ff, chan_ff, 1'b0, rec_cnt_ff, 4'h0,
                   cmd_mode_ff, state_ff};
    else if (haddr[7:0] == rsc_pkg::ADDR_ACT_DIV)
      nxt_rdata = {15'h0, act_div_ff};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h0;
      hrdata_ff  <= 32'h0;
    end
    else
    begin
      wr_pend_ff <= addr_ok && hwrite && haddr[31:8] == 24'h0;
      wr_addr_ff <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata_ff <= haddr[31:8] == 24'h0 ? nxt_rdata : 32'h0;
    end
  end

  // ==========================================================================
  // Configuration registers; out-of-range writes are ignored
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      framing_ff  <= rsc_pkg::FRAMING_RST;
      scan_dur_ff <= rsc_pkg::SCAN_DUR_RST;
      cca_thr_ff  <= rsc_pkg::CCA_THR_RST;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == rsc_pkg::ADDR_FRAMING &&
          hwdata[31:0] <= {30'h0, rsc_pkg::FRAMING_MAX})
        framing_ff <= hwdata[1:0];
      else if (wr_addr_ff == rsc_pkg::ADDR_SCAN_DUR &&
               hwdata <= {29'h0, rsc_pkg::SCAN_DUR_MAX})
        scan_dur_ff <= hwdata[2:0];
      else if (wr_addr_ff == rsc_pkg::ADDR_CCA_THR &&
               hwdata <= {25'h0, rsc_pkg::CCA_THR_MAX})
        cca_thr_ff <= hwdata[6:0];
    end
  end

  // The written rate is rounded to a reachable divisor at once, but the UART
  // keeps its old divisor so the host can still read the OK answer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rate_stored_ff <= rsc_pkg::RATE_RST;
      pend_div_ff    <= rsc_pkg::DIV_RST;
    end
    else if (wr_pend_ff && wr_addr_ff == rsc_pkg::ADDR_RATE)
    begin
      if (hwdata <= {12'h0, rsc_pkg::RATE_CODE_MAX})
      begin
        rate_stored_ff <= hwdata[19:0];
        pend_div_ff    <= std_div(hwdata[2:0]);
      end
      else if (hwdata <= {12'h0, rsc_pkg::RATE_MAX})
      begin
        pend_div_ff    <= near_div(hwdata[19:0]);
        rate_stored_ff <= 20'(rsc_pkg::UART_TICK_HZ /
                              {3'h0, near_div(hwdata[19:0])});
      end
    end
  end

  // Command strobes; a strobe arriving while busy waits for the idle state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scan_go_ff <= 1'b0;
      exit_go_ff <= 1'b0;
    end
    else
    begin
      if (wr_pend_ff && wr_addr_ff == rsc_pkg::ADDR_CTRL &&
          hwdata[rsc_pkg::CTRL_SCAN_BIT])
        scan_go_ff <= 1'b1;
      else if (state_ff == ST_IDLE && !exit_go_ff)
        scan_go_ff <= 1'b0;
      if (wr_pend_ff && wr_addr_ff == rsc_pkg::ADDR_CTRL &&
          hwdata[rsc_pkg::CTRL_EXIT_BIT])
        exit_go_ff <= 1'b1;
      else if (state_ff == ST_IDLE)
        exit_go_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Scan, record streaming and exit sequencing
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff         <= ST_IDLE;
      chan_left_ff     <= 5'h0;
      chan_ff          <= 8'h0;
      timer_ff         <= 28'h0;
      rec_idx_ff       <= 3'h0;
      fld_ff           <= 4'h0;
      byte_ff          <= 4'h0;
      ok_idx_ff        <= 2'h0;
      bcn_req_valid_ff <= 1'b0;
      cmd_mode_ff      <= 1'b1;
      act_div_ff       <= rsc_pkg::DIV_RST;
    end
    else
    begin
      bcn_req_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
          if (exit_go_ff)
          begin
            ok_idx_ff <= 2'h0;
            state_ff  <= ST_OK;
          end
          else if (scan_go_ff)
          begin
            chan_left_ff <= hp_sync_ff ? rsc_pkg::CHAN_CNT_HP
                                       : rsc_pkg::CHAN_CNT_STD;
            chan_ff      <= hp_sync_ff ? rsc_pkg::CHAN_FIRST_HP
                                       : rsc_pkg::CHAN_FIRST_STD;
            state_ff     <= ST_REQ;
          end
        ST_REQ:
        begin
          bcn_req_valid_ff <= 1'b1;
          timer_ff         <= listen_cyc - 28'h1;
          state_ff         <= ST_LISTEN;
        end
        ST_LISTEN:
          if (timer_ff != 28'h0)
            timer_ff <= timer_ff - 28'h1;
          else if (chan_left_ff != 5'h1)
          begin
            chan_left_ff <= chan_left_ff - 5'h1;
            chan_ff      <= chan_ff + 8'h1;
            state_ff     <= ST_REQ;
          end
          else
          begin
            rec_idx_ff <= 3'h0;
            fld_ff     <= 4'h0;
            byte_ff    <= fld_len(recs_ff[0], 4'h0) - 4'h1;
            state_ff   <= rec_cnt_ff == 3'h0 ? ST_FINAL : ST_FIELD;
          end
        ST_FIELD:
          if (resp_free)
          begin
            if (!last_byte)
              byte_ff <= byte_ff - 4'h1;
            else if (framing_ff == rsc_pkg::FRAMING_RST)
              state_ff <= ST_SEP;
            else
              state_ff <= ST_SEP;
          end
        ST_SEP:
          if (resp_free || framing_ff != rsc_pkg::FRAMING_RST)
          begin
            if (!last_fld)
            begin
              fld_ff   <= fld_ff + 4'h1;
              byte_ff  <= fld_len(recs_ff[rec_idx_ff], fld_ff + 4'h1) - 4'h1;
              state_ff <= ST_FIELD;
            end
            else if (rec_idx_ff + 3'h1 != rec_cnt_ff)
            begin
              rec_idx_ff <= rec_idx_ff + 3'h1;
              fld_ff     <= 4'h0;
              byte_ff    <= fld_len(recs_ff[rec_idx_ff + 3'h1], 4'h0) - 4'h1;
              state_ff   <= ST_FIELD;
            end
            else
              state_ff <= ST_FINAL;
          end
        ST_FINAL:
          if (resp_free || framing_ff != rsc_pkg::FRAMING_RST)
            state_ff <= ST_IDLE;
        ST_OK:
          if (resp_free)
          begin
            ok_idx_ff <= ok_idx_ff + 2'h1;
            if (ok_idx_ff == 2'h2)
              state_ff <= ST_APPLY;
          end
        ST_APPLY:
          // Wait until the final OK byte has been taken before switching.
          if (!resp_valid_ff)
          begin
            act_div_ff  <= pend_div_ff;
            cmd_mode_ff <= 1'b0;
            state_ff    <= ST_IDLE;
          end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Beacon capture; later beacons beyond the limit are dropped
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rec_cnt_ff <= 3'h0;
      for (int i = 0; i < rsc_pkg::MAX_RECORDS; i++)
        recs_ff[i] <= '0;
    end
    else if (state_ff == ST_IDLE && scan_go_ff && !exit_go_ff)
      rec_cnt_ff <= 3'h0;
    else if (state_ff == ST_LISTEN && beacon_valid &&
             rec_cnt_ff != 3'(rsc_pkg::MAX_RECORDS))
    begin
      recs_ff[rec_cnt_ff] <= '{bcn: beacon_in, channel: chan_ff};
      rec_cnt_ff          <= rec_cnt_ff + 3'h1;
    end
  end

  // ==========================================================================
  // Response byte stream toward the host UART
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= 8'h0;
    end
    else if (resp_free)
    begin
      resp_valid_ff <= 1'b0;
      if (state_ff == ST_FIELD)
      begin
        resp_valid_ff <= 1'b1;
        resp_data_ff  <= cur_byte;
      end
      else if ((state_ff == ST_SEP || state_ff == ST_FINAL) &&
               framing_ff == rsc_pkg::FRAMING_RST)
      begin
        resp_valid_ff <= 1'b1;
        resp_data_ff  <= rsc_pkg::CHAR_CR;
      end
      else if (state_ff == ST_OK)
      begin
        resp_valid_ff <= 1'b1;
        resp_data_ff  <= ok_idx_ff == 2'h0 ? rsc_pkg::CHAR_O :
                         ok_idx_ff == 2'h1 ? rsc_pkg::CHAR_K :
                                             rsc_pkg::CHAR_CR;
      end
    end
  end

  // ==========================================================================
  // Clear-channel gate: a smaller magnitude means a stronger signal
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cca_go_ff   <= 1'b0;
      cca_drop_ff <= 1'b0;
    end
    else
    begin
      cca_go_ff   <= cca_req && cca_energy_mag >= cca_thr_ff;
      cca_drop_ff <= cca_req && cca_energy_mag < cca_thr_ff;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign hreadyout     = 1'b1 | wr_pend_ff & 1'b0;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_ff;
  assign cca_tx_go     = cca_go_ff;
  assign cca_tx_drop   = cca_drop_ff;
  assign bcn_req_valid = bcn_req_valid_ff;
  assign bcn_req       = '{dst_addr: rsc_pkg::BCAST_ADDR,
                           net_id:   rsc_pkg::BCAST_NET,
                           channel:  chan_ff};
  assign resp_valid    = resp_valid_ff;
  assign resp_data     = resp_data_ff;
  assign framing_mode  = framing_ff;
  assign uart_div      = act_div_ff;
  assign cmd_mode      = cmd_mode_ff;

endmodule : rsc_core

/* include/rsc_pkg.sv */
package rsc_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AHB-Lite bus)
  // ==========================================================================
  localparam logic [7:0]  ADDR_FRAMING   = 8'h00;
  localparam logic [7:0]  ADDR_RATE      = 8'h04;
  localparam logic [7:0]  ADDR_SCAN_DUR  = 8'h08;
  localparam logic [7:0]  ADDR_CCA_THR   = 8'h0c;
  localparam logic [7:0]  ADDR_CTRL      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam logic [7:0]  ADDR_ACT_DIV   = 8'h18;

  localparam int          CTRL_SCAN_BIT  = 0;
  localparam int          CTRL_EXIT_BIT  = 1;

  // ==========================================================================
  // Reset values and ranges
  // ==========================================================================
  localparam logic [1:0]  FRAMING_RST    = 2'h0;
  localparam logic [1:0]  FRAMING_MAX    = 2'h2;
  localparam logic [19:0] RATE_RST       = 20'h00003;
  localparam logic [19:0] RATE_CODE_MAX  = 20'h00007;
  localparam logic [19:0] RATE_MAX       = 20'h3d090;
  localparam logic [2:0]  SCAN_DUR_RST   = 3'h0;
  localparam logic [2:0]  SCAN_DUR_MAX   = 3'h6;
  localparam logic [6:0]  CCA_THR_RST    = 7'h2c;
  localparam logic [6:0]  CCA_THR_MAX    = 7'h50;

  // ==========================================================================
  // Scan constants
  // ==========================================================================
  localparam logic [15:0] BCAST_ADDR     = 16'hffff;
  localparam logic [15:0] BCAST_NET      = 16'hffff;
  localparam logic [7:0]  ADDR_MODE_SHORT = 8'h02;
  localparam logic [7:0]  ADDR_MODE_LONG  = 8'h03;
  localparam logic [4:0]  CHAN_CNT_STD   = 5'h10;
  localparam logic [4:0]  CHAN_CNT_HP    = 5'h0c;
  localparam logic [7:0]  CHAN_FIRST_STD = 8'h0b;
  localparam logic [7:0]  CHAN_FIRST_HP  = 8'h0c;
  localparam int          MAX_RECORDS    = 5;
  localparam int          FIELD_CNT      = 11;
  localparam logic [7:0]  CHAR_CR        = 8'h0d;
  localparam logic [7:0]  CHAR_O         = 8'h4f;
  localparam logic [7:0]  CHAR_K         = 8'h4b;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_PS  = 10000;
  localparam longint      SCAN_BASE_PS   = 64'd15360000000;
  localparam int          SCAN_BASE_CYC  = int'(SCAN_BASE_PS / CLK_PERIOD_PS);
  // UART oversampling clock: 16 MHz reference divided by 16.
  localparam logic [19:0] UART_TICK_HZ   = 20'hf4240;
  localparam logic [16:0] DIV_RST        = 17'h00068;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       assoc_permit;
    logic       net_coord;
    logic       rsvd;
    logic       batt_ext;
    logic [3:0] final_slot;
    logic [3:0] sf_order;
    logic [3:0] bcn_order;
  } rsc_sf_spec_t;

  typedef struct packed {
    logic [63:0]  long_addr;
    logic [15:0]  short_addr;
    logic [15:0]  net_id;
    logic         sec_use;
    logic         acl_entry;
    logic         sec_fail;
    rsc_sf_spec_t sf_spec;
    logic         gts_permit;
    logic [7:0]   rssi_mag;
    logic [23:0]  timestamp;
  } rsc_beacon_t;

  typedef struct packed {
    rsc_beacon_t bcn;
    logic [7:0]  channel;
  } rsc_rec_t;

  typedef struct packed {
    logic [15:0] dst_addr;
    logic [15:0] net_id;
    logic [7:0]  channel;
  } rsc_bcn_req_t;

endpackage : rsc_pkg

/* sim/rsc_chk_properties.sv */
`timescale 1ns/1ps
module rsc_chk (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  cca_req,
  input wire logic                  cca_tx_go,
  input wire logic                  cca_tx_drop,
  input wire logic                  bcn_req_valid,
  input wire rsc_pkg::rsc_bcn_req_t bcn_req,
  input wire logic                  resp_valid,
  input wire logic [7:0]            resp_data,
  input wire logic                  resp_ready,
  input wire logic [1:0]            framing_mode,
  input wire logic [16:0]           uart_div,
  input wire logic                  cmd_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_cca_one: assert property (cca_req |=> cca_tx_go != cca_tx_drop)
    else $error("cca answer is not one pulse");
  a_cca_quiet: assert property (!cca_req |=> !cca_tx_go && !cca_tx_drop)
    else $error("cca answer without request");
  a_req_bcast: assert property (bcn_req_valid |->
    bcn_req.dst_addr == 16'hffff && bcn_req.net_id == 16'hffff)
    else $error("beacon request not broadcast");
  a_req_chan: assert property (bcn_req_valid |->
    bcn_req.channel inside {[8'h0b:8'h1a]})
    else $error("beacon request channel out of range");
  a_req_gap: assert property (bcn_req_valid |=> !bcn_req_valid [*8])
    else $error("listen window too short");
  a_frame_rng: assert property (framing_mode <= 2'h2)
    else $error("framing mode out of range");
  a_resp_hold: assert property (resp_valid && !resp_ready |=>
    resp_valid && $stable(resp_data))
    else $error("stalled byte not held");
  a_rate_hold: assert property (cmd_mode && $past(cmd_mode) |->
    $stable(uart_div))
    else $error("divisor changed in command mode");
  c_scan: cover property (bcn_req_valid);
  c_drop: cover property (cca_tx_drop);
  c_exit: cover property ($fell(cmd_mode));
endmodule : rsc_chk

/* sim/rsc_far.sv */
`timescale 1ns/1ps
module rsc_far (
  input  wire logic                  hclk,
  input  wire logic                  bcn_req_valid,
  input  wire rsc_pkg::rsc_bcn_req_t bcn_req,
  output logic                       beacon_valid,
  output rsc_pkg::rsc_beacon_t       beacon_in,
  output logic                       resp_ready
);
  localparam rsc_pkg::rsc_beacon_t BCN = '{64'h0, 16'h1234, 16'h5678,
    1'b1, 1'b0, 1'b1, 16'h9a53, 1'b1, 8'h2a, 24'h112233};
  logic [2:0] dly_ff = 3'h0;
  logic [1:0] cnt_ff = 2'h0;
  // Only channel 12 has a coordinator; it answers inside the window.
  always_ff @(posedge hclk)
  begin
    dly_ff <= {dly_ff[1:0], bcn_req_valid && bcn_req.channel == 8'h0c};
    cnt_ff <= cnt_ff + 2'h1;
  end
  assign beacon_valid = dly_ff[2];
  // Outside the pulse the record lines carry garbage, not the last value.
  assign beacon_in = beacon_valid ? BCN : ~BCN;
  assign resp_ready = cnt_ff[1];
endmodule : rsc_far

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic                  hclk, hresetn, hsel, hwrite, cca_req;
  logic                  high_power_pin, hreadyout, hresp, cca_tx_go;
  logic                  cca_tx_drop, bcn_req_valid, resp_valid, cmd_mode;
  logic                  beacon_valid, resp_ready;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [1:0]            htrans, framing_mode;
  logic [2:0]            hsize;
  logic [6:0]            cca_energy_mag;
  logic [7:0]            resp_data;
  logic [16:0]           uart_div;
  rsc_pkg::rsc_beacon_t  beacon_in;
  rsc_pkg::rsc_bcn_req_t bcn_req;
  wire                   hready = hreadyout;
  int                    fails = 0, checks = 0, nreq = 0;
  logic [7:0]            q[$];
  logic [127:0]          rec = 128'h12345678020c0100019a53012a112233;
  logic [51:0]           tbl [12] = '{52'h0000000000000,
    52'h0040000000003, 52'h0080000000000, 52'h00c000000002c,
    52'h0180000000068, 52'h1000000300000, 52'h1000000100001,
    52'h10c000510002c, 52'h10c0003400034, 52'h1080000700000,
    52'h1040012c0012b, 52'h1043d0910012b};
  rsc_core #(.SCAN_BASE_CYCLES(10)) dut (.*);
  rsc_far far (.*);
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    if (resp_valid && resp_ready) q.push_back(resp_data);
    if (bcn_req_valid)
      chk({24'h0, bcn_req.channel}, 32'hc + 32'(nreq % 12));
    nreq += int'(bcn_req_valid);
  end
  // ==========================================================================
  // Bus and check tasks
  // ==========================================================================
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    fails += int'(s !== e);
    if (s !== e) $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
  endtask : chk
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task wt;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    fails++;
    test_done;
  endtask : wt
  task wq(input int m);
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge hclk);
      if (q.size() >= m) return;
    end
    fails++;
    test_done;
  endtask : wq
  // Must be entered just after a rising edge.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask : ahb
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {hsel, hwrite, cca_req, high_power_pin, hresetn} = 5'h00;
    {haddr, hwdata, htrans, cca_energy_mag} = 73'h0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (tbl[k])
    begin
      if (tbl[k][48]) ahb(1'b1, tbl[k][47:40], {12'h0, tbl[k][39:20]});
      ahb(1'b0, tbl[k][47:40], 32'h0);
      chk(rd, {12'h0, tbl[k][19:0]});
    end
    for (int k = 0; k < 8; k++)
    begin
      ahb(1'b1, 8'h04, 32'(k));
      ahb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'(k));
    end
    ahb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h68);
    $display("test 1 done");
    for (int k = 0; k < 2; k++)
    begin
      cca_req <= 1'b1;
      cca_energy_mag <= 7'h33 + 7'(k);
      @(posedge hclk);
      cca_req <= 1'b0;
      @(negedge hclk);
      chk({cca_tx_go, cca_tx_drop}, k ? 2'b10 : 2'b01);
      @(posedge hclk);
    end
    $display("test 2 done");
    high_power_pin <= 1'b1;
    ahb(1'b1, 8'h10, 32'h1);
    wq(16);
    repeat (30) @(posedge hclk);
    chk(q.size(), 16);
    chk(nreq, 12);
    foreach (q[k]) chk(q[k], rec[127 - 8 * k -: 8]);
    q.delete();
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h10, 32'h1);
    wq(28);
    repeat (30) @(posedge hclk);
    chk(q.size(), 28);
    chk({q[2], q[27]}, 16'h0d0d);
    q.delete();
    $display("test 3 done");
    ahb(1'b1, 8'h10, 32'h2);
    wq(3);
    chk({q[0], q[1], q[2]}, 24'h4f4b0d);
    for (int n = 0; n < 20 && cmd_mode !== 1'b0; n++) @(posedge hclk);
    chk(cmd_mode, 1'b0);
    ahb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h9);
    chk(uart_div, 17'h9);
    $display("test 4 done");
    test_done;
  end
endmodule : tb
bind rsc_core rsc_chk u_rsc_chk (.*);
